// >>> hw/sscl_map.vh
// Constants for the serial configuration latches of the synthesizer
`ifndef SSCL_MAP_VH
`define SSCL_MAP_VH

`define SSCL_WORD_W      24
`define SSCL_SEL_HI      1
`define SSCL_SEL_LO      0
`define SSCL_CODE_INTFR  2'h0
`define SSCL_CODE_MODREF 2'h1
`define SSCL_CODE_CTRL   2'h2
`define SSCL_CODE_NOISE  2'h3

`define SSCL_FL_BIT      23
`define SSCL_INT_MSB     22
`define SSCL_INT_LSB     14
`define SSCL_FRAC_MSB    13
`define SSCL_FRAC_LSB    2

`define SSCL_LDC_BIT     23
`define SSCL_OSEL_MSB    22
`define SSCL_OSEL_LSB    20
`define SSCL_PRE_MSB     19
`define SSCL_PRE_LSB     18
`define SSCL_RDIV_MSB    17
`define SSCL_RDIV_LSB    14
`define SSCL_MOD_MSB     13
`define SSCL_MOD_LSB     2

`define SSCL_CTRL_W      16
`define SSCL_NOISE_W     11

`define SSCL_RST_INT     9'h01F
`define SSCL_RST_FRAC    12'h000
`define SSCL_RST_MOD     12'h002
`define SSCL_RST_RDIV    4'h1
`define SSCL_RST_OSEL    3'h0
`define SSCL_RST_CTRL    16'h0000
`define SSCL_RST_NOISE   11'h000

`define SSCL_OSEL_OFF    3'h0
`define SSCL_OSEL_LOCK   3'h1
`define SSCL_OSEL_NDIV   3'h2
`define SSCL_OSEL_RDIV   3'h3
`define SSCL_OSEL_ALOCK  3'h4

`endif

// >>> hw/sscl_sync.v
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module sscl_sync #(
	parameter WIDTH = 1
) (
	input  wire             core_clk_i,
	input  wire             rstn_i,
	input  wire             ce_i,
	input  wire [WIDTH-1:0] async_i,
	output reg  [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_ff;

	// First stage is read only by the second stage
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_o  <= {WIDTH{1'b0}};
		end else if (ce_i) begin
			meta_ff <= async_i;
			sync_o  <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// >>> hw/sscl_top.v
// Serial configuration shift register, latches and digital dividers
`timescale 1ns/1ns
`default_nettype none
`include "sscl_map.vh"
module sscl_top #(
	parameter WORD_W = `SSCL_WORD_W,
	parameter INT_W  = 9,
	parameter FRAC_W = 12,
	parameter RDIV_W = 4
) (
	input  wire              core_clk_i,
	input  wire              rstn_i,
	input  wire              ce_i,
	input  wire              ser_clk_i,
	input  wire              ser_data_i,
	input  wire              load_strobe_i,
	input  wire              ref_in_i,
	input  wire              fb_in_i,
	input  wire              lock_raw_i,
	output reg               fast_lock_flag_o,
	output reg  [INT_W-1:0]  int_value_o,
	output reg  [FRAC_W-1:0] frac_value_o,
	output reg  [FRAC_W-1:0] modulus_value_o,
	output reg  [RDIV_W-1:0] ref_div_o,
	output reg               load_control_o,
	output reg  [1:0]        prescaler_o,
	output reg  [2:0]        output_select_o,
	output reg  [15:0]       control_word_o,
	output reg  [10:0]       noise_spur_word_o,
	output reg               ref_div_pulse_o,
	output reg               fb_div_pulse_o,
	output reg               monitor_output_o,
	output reg               lock_det_o,
	output reg               lock_det_oe_o
);
	// ----------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------------------------------
	wire [5:0] pin_sync;
	reg  [2:0] pin_prev_ff;
	wire       sclk_s;
	wire       sdata_s;
	wire       strobe_s;
	wire       ref_s;
	wire       fb_s;
	wire       lock_s;
	wire       sclk_rise;
	wire       strobe_rise;
	wire       ref_rise;

	sscl_sync #(
		.WIDTH (6)
	) u_sync (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.async_i    ({lock_raw_i, fb_in_i, ref_in_i, load_strobe_i, ser_data_i, ser_clk_i}),
		.sync_o     (pin_sync)
	);

	assign sclk_s   = pin_sync[0];
	assign sdata_s  = pin_sync[1];
	assign strobe_s = pin_sync[2];
	assign ref_s    = pin_sync[3];
	assign fb_s     = pin_sync[4];
	assign lock_s   = pin_sync[5];

	reg fb_prev_ff;
	wire fb_rise;

	// Serial clock sampled at 20 MHz; link edges are far slower
	assign sclk_rise   = sclk_s & ~pin_prev_ff[0];
	assign strobe_rise = strobe_s & ~pin_prev_ff[1];
	assign ref_rise    = ref_s & ~pin_prev_ff[2];
	assign fb_rise     = fb_s & ~fb_prev_ff;

	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			pin_prev_ff <= 3'h0;
			fb_prev_ff  <= 1'b0;
		end else if (ce_i) begin
			pin_prev_ff <= {ref_s, strobe_s, sclk_s};
			fb_prev_ff  <= fb_s;
		end
	end

	// ----------------------------------------------------------------
	// Shift register
	// ----------------------------------------------------------------
	reg [WORD_W-1:0] shift_ff;

	// Data and clock share the same sync delay, so data is aligned
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			shift_ff <= {WORD_W{1'b0}};
		end else if (ce_i && sclk_rise) begin
			shift_ff <= {shift_ff[WORD_W-2:0], sdata_s};
		end
	end

	// ----------------------------------------------------------------
	// Latch decode
	// ----------------------------------------------------------------
	function is_code;
		input [WORD_W-1:0] word;
		input [1:0]        code;
		begin
			is_code = ({word[`SSCL_SEL_HI], word[`SSCL_SEL_LO]} == code);
		end
	endfunction

	wire wr_intfr;
	wire wr_modref;
	wire wr_ctrl;
	wire wr_noise;

	assign wr_intfr  = strobe_rise & is_code(shift_ff, `SSCL_CODE_INTFR);
	assign wr_modref = strobe_rise & is_code(shift_ff, `SSCL_CODE_MODREF);
	assign wr_ctrl   = strobe_rise & is_code(shift_ff, `SSCL_CODE_CTRL);
	assign wr_noise  = strobe_rise & is_code(shift_ff, `SSCL_CODE_NOISE);

	// ----------------------------------------------------------------
	// Latches
	// ----------------------------------------------------------------
	reg [FRAC_W-1:0] mod_hold_ff;

	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			fast_lock_flag_o  <= 1'b0;
			int_value_o       <= `SSCL_RST_INT;
			frac_value_o      <= `SSCL_RST_FRAC;
			mod_hold_ff       <= `SSCL_RST_MOD;
			modulus_value_o   <= `SSCL_RST_MOD;
			ref_div_o         <= `SSCL_RST_RDIV;
			load_control_o    <= 1'b0;
			prescaler_o       <= 2'h0;
			output_select_o   <= `SSCL_RST_OSEL;
			control_word_o    <= `SSCL_RST_CTRL;
			noise_spur_word_o <= `SSCL_RST_NOISE;
		end else if (ce_i) begin
			// Each write touches only its own latch, except that the int/frac write also loads the held modulus
			if (wr_intfr) begin
				fast_lock_flag_o <= shift_ff[`SSCL_FL_BIT];
				int_value_o      <= shift_ff[`SSCL_INT_MSB:`SSCL_INT_LSB];
				frac_value_o     <= shift_ff[`SSCL_FRAC_MSB:`SSCL_FRAC_LSB];
				modulus_value_o  <= mod_hold_ff;
			end
			if (wr_modref) begin
				// Only the modulus waits; divider and select act at once
				mod_hold_ff     <= shift_ff[`SSCL_MOD_MSB:`SSCL_MOD_LSB];
				ref_div_o       <= shift_ff[`SSCL_RDIV_MSB:`SSCL_RDIV_LSB];
				load_control_o  <= shift_ff[`SSCL_LDC_BIT];
				prescaler_o     <= shift_ff[`SSCL_PRE_MSB:`SSCL_PRE_LSB];
				output_select_o <= shift_ff[`SSCL_OSEL_MSB:`SSCL_OSEL_LSB];
			end
			if (wr_ctrl) begin
				control_word_o <= shift_ff[`SSCL_CTRL_W-1:0];
			end
			if (wr_noise) begin
				noise_spur_word_o <= shift_ff[`SSCL_NOISE_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Reference divider counter
	// ----------------------------------------------------------------
	reg [RDIV_W-1:0] ref_cnt_ff;
	reg              ref_tgl_ff;
	wire             ref_last;

	// Zero ratio is illegal; it behaves as divide by sixteen here
	// Compare with >= so a lowered ratio cannot run the count past its end
	assign ref_last = (ref_cnt_ff >= ref_div_o - {{(RDIV_W-1){1'b0}}, 1'b1});

	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ref_cnt_ff      <= {RDIV_W{1'b0}};
			ref_div_pulse_o <= 1'b0;
			ref_tgl_ff      <= 1'b0;
		end else if (ce_i) begin
			ref_div_pulse_o <= ref_rise & ref_last;
			if (ref_rise) begin
				if (ref_last) begin
					ref_cnt_ff <= {RDIV_W{1'b0}};
					ref_tgl_ff <= ~ref_tgl_ff;
				end else begin
					ref_cnt_ff <= ref_cnt_ff + {{(RDIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Feedback integer counter with fractional accumulator
	// ----------------------------------------------------------------
	reg  [INT_W-1:0]  fb_cnt_ff;
	reg  [FRAC_W-1:0] frac_acc_ff;
	reg               carry_ff;
	reg               fb_tgl_ff;
	wire [INT_W-1:0]  fb_last_cnt;
	wire              fb_last;
	wire [FRAC_W:0]   acc_sum;
	wire              acc_wrap;

	// A carry stretches the next cycle by one feedback edge
	assign fb_last_cnt = int_value_o - {{(INT_W-1){1'b0}}, ~carry_ff};
	// A smaller integer value must not leave the count beyond its end
	assign fb_last     = (fb_cnt_ff >= fb_last_cnt);
	assign acc_sum     = {1'b0, frac_acc_ff} + {1'b0, frac_value_o};
	assign acc_wrap    = (acc_sum >= {1'b0, modulus_value_o});

	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			fb_cnt_ff      <= {INT_W{1'b0}};
			frac_acc_ff    <= {FRAC_W{1'b0}};
			carry_ff       <= 1'b0;
			fb_div_pulse_o <= 1'b0;
			fb_tgl_ff      <= 1'b0;
		end else if (ce_i) begin
			fb_div_pulse_o <= fb_rise & fb_last;
			if (fb_rise) begin
				if (fb_last) begin
					fb_cnt_ff <= {INT_W{1'b0}};
					fb_tgl_ff <= ~fb_tgl_ff;
					carry_ff  <= acc_wrap;
					if (acc_wrap) begin
						frac_acc_ff <= acc_sum[FRAC_W-1:0] - modulus_value_o;
					end else begin
						frac_acc_ff <= acc_sum[FRAC_W-1:0];
					end
				end else begin
					fb_cnt_ff <= fb_cnt_ff + {{(INT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Monitor output and lock detect
	// ----------------------------------------------------------------
	reg nxt_monitor;

	always @* begin
		case (output_select_o)
			`SSCL_OSEL_OFF:   nxt_monitor = 1'b0;
			`SSCL_OSEL_LOCK:  nxt_monitor = lock_s;
			`SSCL_OSEL_NDIV:  nxt_monitor = fb_tgl_ff;
			`SSCL_OSEL_RDIV:  nxt_monitor = ref_tgl_ff;
			`SSCL_OSEL_ALOCK: nxt_monitor = lock_s & ~ref_div_pulse_o;
			default:          nxt_monitor = 1'b0;
		endcase
	end

	// Pin only ever pulls low; the external pull-up makes the high
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			monitor_output_o <= 1'b0;
			lock_det_o       <= 1'b0;
			lock_det_oe_o    <= 1'b1;
		end else if (ce_i) begin
			monitor_output_o <= nxt_monitor;
			lock_det_o       <= 1'b0;
			lock_det_oe_o    <= ~lock_s | ref_div_pulse_o;
		end
	end
endmodule
`default_nettype wire

// >>> tb/sscl_monitor.sv
// Assertion checker for the serial configuration latches
`timescale 1ns/1ns
`default_nettype none
module sscl_monitor (
	input wire logic        core_clk_i,
	input wire logic        rstn_i,
	input wire logic        ce_i,
	input wire logic        load_strobe_i,
	input wire logic        lock_raw_i,
	input wire logic        fast_lock_flag_o,
	input wire logic [8:0]  int_value_o,
	input wire logic [11:0] frac_value_o,
	input wire logic [11:0] modulus_value_o,
	input wire logic [3:0]  ref_div_o,
	input wire logic        load_control_o,
	input wire logic [1:0]  prescaler_o,
	input wire logic [2:0]  output_select_o,
	input wire logic [15:0] control_word_o,
	input wire logic [10:0] noise_spur_word_o,
	input wire logic        ref_div_pulse_o,
	input wire logic        fb_div_pulse_o,
	input wire logic        monitor_output_o,
	input wire logic        lock_det_oe_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	// Frozen state is legal while the clock enable is low
	default disable iff (!rstn_i || !ce_i);
	intfr_hold_a: assert property ($changed({fast_lock_flag_o, int_value_o, frac_value_o,
		modulus_value_o}) |-> $past(load_strobe_i)) else $error("int word moved without strobe");
	modref_hold_a: assert property ($changed({ref_div_o, load_control_o, prescaler_o,
		output_select_o}) |-> $past(load_strobe_i)) else $error("mod word moved without strobe");
	other_hold_a: assert property ($changed({control_word_o, noise_spur_word_o})
		|-> $past(load_strobe_i)) else $error("ctrl or noise moved without strobe");
	mod_buffer_a: assert property ($changed(ref_div_o) |-> $stable(modulus_value_o))
		else $error("modulus acted on mod write");
	ref_pulse_a: assert property (ref_div_pulse_o |=> !ref_div_pulse_o)
		else $error("ref pulse too long");
	fb_pulse_a: assert property (fb_div_pulse_o |=> !fb_div_pulse_o)
		else $error("fb pulse too long");
	unlock_low_a: assert property (!lock_raw_i [*8] |-> lock_det_oe_o)
		else $error("lock pin not low when unlocked");
	lock_brief_a: assert property (lock_raw_i [*8] ##1 lock_det_oe_o |=> !lock_det_oe_o)
		else $error("lock low pulse not brief");
	mon_off_a: assert property (output_select_o == 3'h0 && $past(output_select_o) == 3'h0
		|-> !monitor_output_o) else $error("monitor active while off");
	cover property ($changed(modulus_value_o));
	cover property ($changed(noise_spur_word_o));
	cover property (lock_raw_i [*8] ##1 lock_det_oe_o);
endmodule
bind sscl_top sscl_monitor sscl_monitor_inst (.*);
`default_nettype wire

// >>> tb/sscl_host.sv
// Host model driving the three serial configuration pins
`timescale 1ns/1ns
`default_nettype none
module sscl_host (
	input  wire logic core_clk_i,
	output var  logic ser_clk_o,
	output var  logic ser_data_o,
	output var  logic load_strobe_o
);
	initial begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
		load_strobe_o = 1'b0;
	end
	// Eight core cycles a bit; clock idles low between frames
	task automatic shift(input logic [23:0] w, input int n);
		for (int i = 23; i > 23 - n; i--) begin
			@(posedge core_clk_i) ser_data_o <= w[i];
			repeat (2) @(posedge core_clk_i);
			ser_clk_o <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			ser_clk_o <= 1'b0;
			@(posedge core_clk_i);
		end
		// Released data must not look like the last bit
		ser_data_o <= ~ser_data_o;
	endtask
	task automatic load();
		repeat (4) @(posedge core_clk_i);
		load_strobe_o <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		load_strobe_o <= 1'b0;
		repeat (4) @(posedge core_clk_i);
	endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking testbench for the serial configuration latches
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        core_clk_i, rstn_i, ref_in_i, fb_in_i, lock_raw_i, ce;
	logic        ser_clk, ser_data, strobe, fl, lc, mon, rp, fp, ld, ld_oe;
	logic [8:0]  iv;
	logic [11:0] fv, mv, hold;
	logic [3:0]  rd, cnt = 4'h0;
	logic [1:0]  pre;
	logic [2:0]  osel;
	logic [15:0] ctrl;
	logic [10:0] noise;
	logic [70:0] exp;
	int          mismatches = 0, compares = 0, n_ref, n_fb, n_tgl, n_oe;
	wire  [70:0] got = {fl, iv, fv, mv, rd, lc, pre, osel, ctrl, noise};
	localparam logic [70:0] RST = {1'h0, 9'h01F, 24'h000002, 4'h1, 6'h00, 27'h0};
	// Words only; the mirror works out what each should leave behind
	logic [23:0] rows [7] = '{24'hA56789, 24'h00ABCE, 24'hFFF7FF, 24'h3C0A14,
		24'h7FFFFC, 24'h1FC009, 24'h07C000};
	sscl_host sscl_host_inst (.core_clk_i(core_clk_i), .ser_clk_o(ser_clk),
		.ser_data_o(ser_data), .load_strobe_o(strobe));
	sscl_top sscl_top_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce),
		.ser_clk_i(ser_clk), .ser_data_i(ser_data), .load_strobe_i(strobe),
		.ref_in_i(ref_in_i), .fb_in_i(fb_in_i), .lock_raw_i(lock_raw_i),
		.fast_lock_flag_o(fl), .int_value_o(iv), .frac_value_o(fv), .modulus_value_o(mv),
		.ref_div_o(rd), .load_control_o(lc), .prescaler_o(pre), .output_select_o(osel),
		.control_word_o(ctrl), .noise_spur_word_o(noise), .ref_div_pulse_o(rp),
		.fb_div_pulse_o(fp), .monitor_output_o(mon), .lock_det_o(ld), .lock_det_oe_o(ld_oe));
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cnt <= cnt + 4'h1;
		ref_in_i <= cnt[2];
		fb_in_i <= cnt[3];
	end
	task automatic chk(input logic [70:0] g, e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apply(input logic [23:0] w);
		case (w[1:0])
			2'h0: exp[70:37] = {w[23:2], hold};
			2'h1: begin
				hold = w[13:2];
				exp[36:27] = {w[17:14], w[23], w[19:18], w[22:20]};
			end
			2'h2: exp[26:11] = w[15:0];
			default: exp[10:0] = w[10:0];
		endcase
	endtask
	task automatic send(input logic [23:0] w);
		sscl_host_inst.shift(w, 24);
		sscl_host_inst.load();
		apply(w);
		#1 chk(got, exp);
	endtask
	// Counts pulses and monitor changes over a window, sampled off the edge
	task automatic tally(input int len);
		logic m;
		n_ref = 0;
		n_fb = 0;
		n_tgl = 0;
		n_oe = 0;
		m = mon;
		repeat (len) begin
			@(posedge core_clk_i);
			#1;
			n_ref += int'(rp);
			n_fb += int'(fp);
			n_tgl += int'(mon != m);
			n_oe += int'(ld_oe);
			m = mon;
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#2000000;
		mismatches++;
		give_verdict();
	end
	initial begin
		rstn_i = 1'b0;
		ce = 1'b1;
		lock_raw_i = 1'b0;
		exp = RST;
		hold = 12'h002;
		repeat (10) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 chk(got, exp);
		chk(71'(ld_oe), 71'h1);
		chk(71'(ld), 71'h0);
		foreach (rows[i]) send(rows[i]);
		// Leading junk bits must fall off the top
		sscl_host_inst.shift(24'hFFFFFF, 6);
		send(24'h001232);
		@(posedge core_clk_i) lock_raw_i <= 1'b1;
		repeat (10) @(posedge core_clk_i);
		#1 tally(240);
		chk(71'(n_oe >= 1 && n_oe <= 4), 71'h1);
		chk(71'(mon), 71'h1);
		@(posedge core_clk_i) lock_raw_i <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		#1 chk(71'(ld_oe), 71'h1);
		chk(71'(mon), 71'h0);
		// Frozen block must ignore a whole frame and its strobe
		@(posedge core_clk_i) ce <= 1'b0;
		sscl_host_inst.shift(24'h3C0A14, 24);
		sscl_host_inst.load();
		#1 chk(got, exp);
		@(posedge core_clk_i) ce <= 1'b1;
		@(posedge core_clk_i) rstn_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 chk(got, RST);
		exp = RST;
		hold = 12'h002;
		// Ratio three on an eight-cycle reference: one pulse every 24 cycles
		send(24'h30C009);
		tally(240);
		chk(71'(n_ref), 71'hA);
		chk(71'(n_tgl), 71'hA);
		// Reset ratio 31 on a 16-cycle feedback input: one pulse every 496 cycles
		send(24'h20C009);
		tally(992);
		chk(71'(n_fb), 71'h2);
		chk(71'(n_tgl), 71'h2);
		@(posedge core_clk_i) lock_raw_i <= 1'b1;
		send(24'h40C009);
		tally(240);
		chk(71'(n_oe), 71'hA);
		chk(71'(n_tgl), 71'h14);
		give_verdict();
	end
endmodule
`default_nettype wire
